/* File: sdrc_pkg.sv */
// package: constants and types for the converter rate and calibration control
package sdrc_pkg;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 10000000;
    localparam int MOD_DIVISOR = 512;
    localparam logic [8:0] MOD_DIV_LAST = 9'h1FF;
    localparam int SCLK_HALF = 1;
    // rate multiplier and gain codes are log2 of the factor
    localparam logic [2:0] LOG2_MAX_PRODUCT = 3'h4;
    localparam int DECIM_W = 13;
    localparam int RESULT_W = 24;
    localparam int HISTORY = 3;
    // ---------------------------------------------------------------
    // APB register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_DECIM = 8'h04;
    localparam logic [7:0] ADDR_CALCTL = 8'h08;
    localparam logic [7:0] ADDR_OFFSET = 8'h0C;
    localparam logic [7:0] ADDR_GAINC = 8'h10;
    localparam logic [7:0] ADDR_RESULT = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    // field positions
    localparam int CFG_TURBO_LSB = 0;
    localparam int CFG_GAIN_LSB = 4;
    localparam int CFG_MASTER_BIT = 8;
    localparam int CAL_SELF_BIT = 0;
    localparam int CAL_BG_BIT = 1;
    localparam int CAL_SYS_BIT = 2;
    // reset values
    localparam logic [DECIM_W-1:0] DECIM_RESET = 13'h0013;
    localparam logic [23:0] OFFSET_RESET = 24'h000000;
    localparam logic [23:0] GAINC_RESET = 24'h800000;
    // calibration run length in result periods
    localparam logic [1:0] CAL_PERIODS = 2'h3;

    typedef enum {CAL_IDLE, CAL_SELF, CAL_SYS, CAL_BG} cal_state_t;

    typedef struct packed {
        logic [2:0] turbo;
        logic [2:0] gain;
        logic master;
    } rate_cfg_t;

    typedef struct packed {
        logic modTick;
        logic sampTick;
        logic dataTick;
    } rate_ticks_t;
endpackage : sdrc_pkg

/* File: rate_divider.sv */
// module: clock-enable dividers for modulator, sampling and data rates
`timescale 1ns/1ps
module rate_divider (
    input wire logic clk,
    input wire logic reset,
    input wire sdrc_pkg::rate_cfg_t cfg,
    input wire logic [sdrc_pkg::DECIM_W-1:0] decim,
    output sdrc_pkg::rate_ticks_t ticks
);
    logic [8:0] phase;
    logic [sdrc_pkg::DECIM_W-1:0] decCount;
    logic [8:0] modStep;
    logic [8:0] sampStep;

    // step sizes: the period of 512 clocks is split by the factor
    always_comb begin
        modStep = 9'(sdrc_pkg::MOD_DIV_LAST >> cfg.turbo);
        sampStep = 9'(sdrc_pkg::MOD_DIV_LAST >> (cfg.turbo + cfg.gain));
    end

    // ---------------------------------------------------------------
    // phase counter and tick generation
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            phase <= 9'h000;
            ticks <= '0;
            decCount <= '0;
        end else begin
            phase <= phase + 9'h001;
            // modulator at clk * turbo / 512
            ticks.modTick <= ((phase & modStep) == modStep);
            // sampling at clk * turbo * gain / 512
            ticks.sampTick <= ((phase & sampStep) == sampStep);
            ticks.dataTick <= 1'b0;
            // data rate only counts modulator ticks
            if ((phase & modStep) == modStep) begin
                if (decCount >= decim) begin
                    decCount <= '0;
                    ticks.dataTick <= 1'b1;
                end else begin
                    decCount <= decCount + 1'b1;
                end
            end
        end
    end
endmodule : rate_divider

/* File: sigma_delta_rate_and_calibration_control.sv */
// module: rate, calibration and register control of a delta-sigma converter
// Functional notes
// - modulator rate is clk times turbo over 512
// - sampling rate adds gain factor to that
// - data rate divides modulator rate by decimation+1
// - decimation changes only data rate
// - result combines last three data periods
// - master serial clock is half system clock
// - all settings reached through serial register port
// - self calibration single or background
// - system calibration on request only
// - calibration coefficients fully readable and writable
// - result is signed two-sided code
// - command register sets turbo multiplier
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module sigma_delta_rate_and_calibration_control (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic modBit,
    output logic modulatorRate,
    output logic inputSamplingRate,
    output logic resultReadyFlag,
    output logic serialClock,
    output logic serialClockOe_n,
    output logic calBusy
);
    sdrc_pkg::rate_cfg_t cfg;
    sdrc_pkg::rate_ticks_t ticks;
    sdrc_pkg::cal_state_t calState;
    logic [sdrc_pkg::DECIM_W-1:0] decim;
    logic [23:0] offsetCoef;
    logic [23:0] gainCoef;
    logic [23:0] periodSum [sdrc_pkg::HISTORY];
    logic [23:0] accum;
    logic signed [23:0] result;
    logic [1:0] calCount;
    logic calStart;
    logic sysStart;
    logic bgEnable;
    logic rejectCfg;
    logic wrStrobe;
    logic rdStrobe;
    logic mapped;
    logic [31:0] readMux;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // legal when log2(turbo)+log2(gain) stays within log2(16)
    function automatic logic legal_pair(input logic [2:0] t,
                                        input logic [2:0] g);
        legal_pair = ({1'b0, t} + {1'b0, g}) <=
                     {1'b0, sdrc_pkg::LOG2_MAX_PRODUCT};
    endfunction : legal_pair

    // unmapped offsets answer with pslverr and read as zero
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == sdrc_pkg::ADDR_CONFIG) ||
                    (a == sdrc_pkg::ADDR_DECIM) ||
                    (a == sdrc_pkg::ADDR_CALCTL) ||
                    (a == sdrc_pkg::ADDR_OFFSET) ||
                    (a == sdrc_pkg::ADDR_GAINC) ||
                    (a == sdrc_pkg::ADDR_RESULT) ||
                    (a == sdrc_pkg::ADDR_STATUS);
    endfunction : is_mapped

    // ---------------------------------------------------------------
    // APB decode: zero-wait access, error on unmapped or illegal pair
    // ---------------------------------------------------------------
    // reads are fetched at setup so prdata is ready in the access cycle;
    // writes land at the edge that samples pready high, so a setup that
    // is never completed cannot change a register
    always_comb begin
        wrStrobe = psel && penable && pready && pwrite;
        rdStrobe = psel && !penable && !pwrite;
        mapped = is_mapped(paddr);
        // host owns a bad turbo/gain pair is refused here
        rejectCfg = (paddr == sdrc_pkg::ADDR_CONFIG) && !legal_pair(
            pwdata[sdrc_pkg::CFG_TURBO_LSB +: 3],
            pwdata[sdrc_pkg::CFG_GAIN_LSB +: 3]);
        calStart = wrStrobe && mapped && paddr == sdrc_pkg::ADDR_CALCTL &&
                   pwdata[sdrc_pkg::CAL_SELF_BIT];
        sysStart = wrStrobe && mapped && paddr == sdrc_pkg::ADDR_CALCTL &&
                   pwdata[sdrc_pkg::CAL_SYS_BIT];
    end

    // read mux: every setting and coefficient is visible
    // coefficients read back as stored, for save and restore per setting
    always_comb begin
        case (paddr)
            sdrc_pkg::ADDR_CONFIG: readMux = {23'h0, cfg.master, 1'b0,
                                              cfg.gain, 1'b0, cfg.turbo};
            sdrc_pkg::ADDR_DECIM: readMux = {19'h0, decim};
            sdrc_pkg::ADDR_CALCTL: readMux = {30'h0, bgEnable, 1'b0};
            sdrc_pkg::ADDR_OFFSET: readMux = {8'h00, offsetCoef};
            sdrc_pkg::ADDR_GAINC: readMux = {8'h00, gainCoef};
            // sign extended two-sided code
            sdrc_pkg::ADDR_RESULT: readMux = {{8{result[23]}}, result};
            sdrc_pkg::ADDR_STATUS: readMux = {29'h0, calBusy,
                                              resultReadyFlag, cfg.master};
            default: readMux = 32'h00000000;
        endcase
    end

    // bus answer registered one cycle after setup; pready high in access
    // every access completes in one cycle, so no wait state is ever added
    always_ff @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable &&
                       (!mapped || (pwrite && rejectCfg));
            if (rdStrobe) begin
                prdata <= readMux;
            end
        end
    end

    // ---------------------------------------------------------------
    // configuration registers, written in the access cycle
    // an illegal multiplier and gain pair leaves every field unchanged,
    // so the dividers never run a combination the front end cannot take
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg <= '0;
            decim <= sdrc_pkg::DECIM_RESET;
            bgEnable <= 1'b0;
        end else if (wrStrobe && mapped) begin
            case (paddr)
                sdrc_pkg::ADDR_CONFIG: begin
                    if (!rejectCfg) begin
                        // turbo multiplier from command word
                        cfg.turbo <= pwdata[sdrc_pkg::CFG_TURBO_LSB +: 3];
                        cfg.gain <= pwdata[sdrc_pkg::CFG_GAIN_LSB +: 3];
                        // mode bit chosen by host
                        cfg.master <= pwdata[sdrc_pkg::CFG_MASTER_BIT];
                    end
                end
                // decimation alters only the data divider
                sdrc_pkg::ADDR_DECIM: decim <= pwdata[sdrc_pkg::DECIM_W-1:0];
                // background mode is self calibration only
                sdrc_pkg::ADDR_CALCTL: bgEnable <= pwdata[sdrc_pkg::CAL_BG_BIT];
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // rate generation
    // ---------------------------------------------------------------
    // all rates share one free-running phase: every tick lands where the
    // low phase bits are all ones, so a new factor applies at the next one
    rate_divider u_div (
        .clk(clk),
        .reset(reset),
        .cfg(cfg),
        .decim(decim),
        .ticks(ticks)
    );

    // registered rate strobes
    // one stage keeps the pins on flip-flops; they trail the ticks by one
    always_ff @(posedge clk) begin
        if (reset) begin
            modulatorRate <= 1'b0;
            inputSamplingRate <= 1'b0;
        end else begin
            modulatorRate <= ticks.modTick;
            inputSamplingRate <= ticks.sampTick;
        end
    end

    // master clock toggles every cycle: half the system clock
    // clock and pin enable follow the same mode bit at the same edge, so
    // no stray clock level leaves the pin while it changes direction
    always_ff @(posedge clk) begin
        if (reset) begin
            serialClock <= 1'b0;
            serialClockOe_n <= 1'b1;
        end else begin
            serialClock <= cfg.master ? ~serialClock : 1'b0;
            // pin released in slave mode, clock comes from host
            serialClockOe_n <= ~cfg.master;
        end
    end

    // ---------------------------------------------------------------
    // filter stand-in: bit counts over the last three periods
    // ---------------------------------------------------------------
    // the real sinc3 arithmetic lives elsewhere; this keeps the window
    // limitation: one count per modulator bit and no gain scaling, so the
    // code only carries the sign and rough size of the input
    always_ff @(posedge clk) begin
        if (reset) begin
            accum <= 24'h000000;
            for (int i = 0; i < sdrc_pkg::HISTORY; i++) begin
                periodSum[i] <= 24'h000000;
            end
        end else if (ticks.dataTick) begin
            // shift period totals; output uses accum and the two newest, periodSum[2] feeds only the background trim
            periodSum[0] <= accum;
            periodSum[1] <= periodSum[0];
            periodSum[2] <= periodSum[1];
            // the closing tick also opens the next period and counts +1
            // or -1 like any other, so no period starts with a bias
            accum <= modBit ? 24'h000001 : 24'hFFFFFF;
        end else if (ticks.modTick) begin
            // +1 for a one, -1 for a zero: two-sided sum
            accum <= modBit ? accum + 24'h000001 : accum - 24'h000001;
        end
    end

    // result corrected by the offset coefficient
    // the gain coefficient is only kept for save and restore; scaling
    // belongs to the filter arithmetic outside this block
    always_ff @(posedge clk) begin
        if (reset) begin
            result <= '0;
            resultReadyFlag <= 1'b0;
        end else begin
            resultReadyFlag <= 1'b0;
            if (ticks.dataTick) begin
                result <= signed'(periodSum[0] + periodSum[1] + accum
                                  - offsetCoef);
                // one pulse per data period
                resultReadyFlag <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // calibration sequencer
    // ---------------------------------------------------------------
    // on-demand runs end on their third data tick and store the offset;
    // background trims every period until its enable is cleared; a start
    // request during a run is dropped rather than queued
    always_ff @(posedge clk) begin
        if (reset) begin
            calState <= sdrc_pkg::CAL_IDLE;
            calCount <= 2'h0;
            calBusy <= 1'b0;
            offsetCoef <= sdrc_pkg::OFFSET_RESET;
            gainCoef <= sdrc_pkg::GAINC_RESET;
        end else begin
            // a sequencer store in the same cycle wins over a host write
            if (wrStrobe && paddr == sdrc_pkg::ADDR_OFFSET) begin
                offsetCoef <= pwdata[23:0];
            end
            if (wrStrobe && paddr == sdrc_pkg::ADDR_GAINC) begin
                gainCoef <= pwdata[23:0];
            end
            case (calState)
                sdrc_pkg::CAL_IDLE: begin
                    calCount <= 2'h0;
                    calBusy <= 1'b0;
                    if (sysStart) begin
                        // host must have applied inputs already
                        calState <= sdrc_pkg::CAL_SYS;
                        calBusy <= 1'b1;
                    end else if (calStart) begin
                        calState <= sdrc_pkg::CAL_SELF;
                        calBusy <= 1'b1;
                    end else if (bgEnable) begin
                        calState <= sdrc_pkg::CAL_BG;
                    end
                end
                sdrc_pkg::CAL_SELF, sdrc_pkg::CAL_SYS: begin
                    // ends on the third data tick, then stops
                    if (ticks.dataTick) begin
                        calCount <= calCount + 2'h1;
                        if (calCount == sdrc_pkg::CAL_PERIODS - 2'h1) begin
                            offsetCoef <= periodSum[0];
                            calState <= sdrc_pkg::CAL_IDLE;
                        end
                    end
                end
                sdrc_pkg::CAL_BG: begin
                    // background trim alongside conversions
                    if (ticks.dataTick) begin
                        offsetCoef <= periodSum[2];
                    end
                    if (!bgEnable) begin
                        calState <= sdrc_pkg::CAL_IDLE;
                    end
                end
                default: calState <= sdrc_pkg::CAL_IDLE;
            endcase
        end
    end
endmodule : sigma_delta_rate_and_calibration_control

/* File: sdrc_monitor.sv */
// checker: port relations of the rate and calibration control block
`timescale 1ns/1ps
module sdrc_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic modulatorRate,
    input wire logic inputSamplingRate,
    input wire logic resultReadyFlag,
    input wire logic serialClock,
    input wire logic serialClockOe_n,
    input wire logic calBusy
);
    // ---------------------------------------------------------------
    // assertions, all in the one clock domain
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer one cycle after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("pready held past the access cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr outside the access cycle");
    master_toggle_a: assert property (
        !serialClockOe_n && $past(!serialClockOe_n)
        |-> serialClock != $past(serialClock))
        else $error("master serial clock not at half rate");
    slave_quiet_a: assert property (serialClockOe_n |-> !serialClock)
        else $error("serial clock driven in slave mode");
    mod_spacing_a: assert property (
        modulatorRate |=> !modulatorRate [*8])
        else $error("modulator ticks closer than the fastest rate");
    mod_bound_a: assert property (
        modulatorRate |-> ##[1:512] modulatorRate)
        else $error("modulator tick gap beyond 512 clocks");
    samp_on_mod_a: assert property (
        modulatorRate |-> inputSamplingRate)
        else $error("sampling tick missing on a modulator tick");
    ready_spacing_a: assert property (
        resultReadyFlag |=> !resultReadyFlag [*8])
        else $error("result ready pulses too close");
    cal_hold_a: assert property ($rose(calBusy) |=> calBusy [*8])
        else $error("calibration busy dropped too soon");
    // main scenarios reached
    cover property ($fell(calBusy));
    cover property (pslverr);
    cover property (resultReadyFlag);
    cover property (!serialClockOe_n);
endmodule : sdrc_monitor

/* File: main_controller_model.sv */
// partner: main controller issuing register transfers to the converter
`timescale 1ns/1ps
module main_controller_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // idle bus from time zero
    initial begin
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h00000000;
    end
    // one transfer: setup, access held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count assumed: only the bench watchdog ends this wait
        do begin
            @(posedge clk);
        end while (!pready);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show the inverse so stale values never match
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : main_controller_model

/* File: sigma_delta_rate_and_calibration_control_bench.sv */
// testbench: register, rate, clocking and calibration scenarios
`timescale 1ns/1ps
module sigma_delta_rate_and_calibration_control_bench;
    // ---------------------------------------------------------------
    // wiring and tables
    // ---------------------------------------------------------------
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic e;
    } row_t;
    // read rows give q; write rows give only the error flag
    localparam row_t ROWS [0:14] = '{
        '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h04, 32'h0, 32'h13, 1'b0},
        '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h10, 32'h0, 32'h800000, 1'b0},
        '{1'b1, 8'h0C, 32'h123456, 32'h0, 1'b0},
        '{1'b0, 8'h0C, 32'h0, 32'h123456, 1'b0},
        '{1'b1, 8'h10, 32'h7ABCDE, 32'h0, 1'b0},
        '{1'b0, 8'h10, 32'h0, 32'h7ABCDE, 1'b0},
        '{1'b1, 8'h00, 32'h14, 32'h0, 1'b1},
        '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h1C, 32'h0, 32'h0, 1'b1},
        '{1'b1, 8'h00, 32'h22, 32'h0, 1'b0},
        '{1'b0, 8'h00, 32'h0, 32'h22, 1'b0},
        '{1'b1, 8'h0C, 32'h0, 32'h0, 1'b0},
        '{1'b1, 8'h10, 32'h800000, 32'h0, 1'b0}};
    logic clk, reset, modBit, psel, penable, pwrite, pready, pslverr, e, s0;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r, n;
    logic modulatorRate, inputSamplingRate, resultReadyFlag;
    logic serialClock, serialClockOe_n, calBusy;
    logic [2:0] tick;
    int miscompares = 0;
    int cmp_count = 0;
    assign tick = {resultReadyFlag, inputSamplingRate, modulatorRate};
    sigma_delta_rate_and_calibration_control DUT (.clk(clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .modBit(modBit), .modulatorRate(modulatorRate),
        .inputSamplingRate(inputSamplingRate),
        .resultReadyFlag(resultReadyFlag), .serialClock(serialClock),
        .serialClockOe_n(serialClockOe_n), .calBusy(calBusy));
    main_controller_model model (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] x,
            input logic [31:0] y);
        cmp_count++;
        if (y !== x) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, y);
        end
    endtask : chk
    // skips two ticks so a rate change has settled, then counts one gap
    task automatic gap(input int k, output logic [31:0] c);
        int i;
        i = 0;
        repeat (2) begin
            do begin
                @(posedge clk);
                i++;
            end while (tick[k] !== 1'b1 && i < 9000);
        end
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (tick[k] !== 1'b1 && c < 9000);
    endtask : gap
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    // ---------------------------------------------------------------
    // clock, watchdog and main sequence
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // about three times the cycles the whole sequence should need
    initial begin
        #3000000;
        miscompares++;
        test_done();
    end
    initial begin
        reset <= 1'b1;
        modBit <= 1'b0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        chk("oe_n", 32'h1, {31'h0, serialClockOe_n});
        chk("outs", 32'h0, {26'h0, modulatorRate, resultReadyFlag,
            serialClock, calBusy, pready, pslverr});
        foreach (ROWS[k]) begin
            model.xfer(ROWS[k].w, ROWS[k].a, ROWS[k].d, r, e);
            if (!ROWS[k].w) chk("row data", ROWS[k].q, r);
            chk("row err", {31'h0, ROWS[k].e}, {31'h0, e});
        end
        model.xfer(1'b1, 8'h04, 32'h1, r, e);
        // every legal turbo with the largest gain it allows
        for (int t = 0; t <= 4; t++) begin
            model.xfer(1'b1, 8'h00, 32'(t + ((4 - t) << 4)), r, e);
            gap(0, n);
            chk("mod gap", 32'(512 >> t), n);
            gap(1, n);
            chk("samp gap", 32'h20, n);
            gap(2, n);
            chk("data gap", 32'(1024 >> t), n);
        end
        model.xfer(1'b1, 8'h00, 32'h4, r, e);
        model.xfer(1'b1, 8'h04, 32'h3, r, e);
        gap(0, n);
        chk("mod gap", 32'h20, n);
        gap(1, n);
        chk("samp gap", 32'h20, n);
        gap(2, n);
        chk("data gap", 32'h80, n);
        modBit <= 1'b1;
        repeat (520) @(posedge clk);
        model.xfer(1'b0, 8'h14, 32'h0, r, e);
        chk("positive sign", 32'h0, {31'h0, r[31]});
        modBit <= 1'b0;
        repeat (520) @(posedge clk);
        model.xfer(1'b0, 8'h14, 32'h0, r, e);
        chk("negative sign", 32'h1, {31'h0, r[31]});
        model.xfer(1'b1, 8'h00, 32'h104, r, e);
        repeat (2) @(posedge clk);
        s0 = serialClock;
        @(posedge clk);
        chk("sclk toggle", {31'h0, ~s0}, {31'h0, serialClock});
        chk("oe_n master", 32'h0, {31'h0, serialClockOe_n});
        model.xfer(1'b0, 8'h18, 32'h0, r, e);
        chk("status master", 32'h1, {31'h0, r[0]});
        model.xfer(1'b1, 8'h00, 32'h4, r, e);
        // on-demand self run, then system run: the run ends on its third
        // data tick, so busy lasts two to three periods of 128 clocks
        for (int k = 0; k < 2; k++) begin
            model.xfer(1'b1, 8'h08, k ? 32'h4 : 32'h1, r, e);
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (calBusy && n < 2000);
            s0 = (n >= 32'h100 && n <= 32'h188);
            chk("cal span", 32'h1, {31'h0, s0});
        end
        repeat (200) @(posedge clk);
        chk("no sys repeat", 32'h0, {31'h0, calBusy});
        // clear the offset so the background trim has to move it
        model.xfer(1'b1, 8'h0C, 32'h0, r, e);
        model.xfer(1'b1, 8'h08, 32'h2, r, e);
        repeat (300) @(posedge clk);
        chk("bg not busy", 32'h0, {31'h0, calBusy});
        model.xfer(1'b0, 8'h0C, 32'h0, r, e);
        chk("bg trim", 32'h1, {31'h0, r[23:0] != 24'h000000});
        model.xfer(1'b1, 8'h08, 32'h0, r, e);
        test_done();
    end
endmodule : sigma_delta_rate_and_calibration_control_bench
bind sigma_delta_rate_and_calibration_control sdrc_monitor mon (.clk(clk),
    .reset(reset), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .modulatorRate(modulatorRate),
    .inputSamplingRate(inputSamplingRate), .resultReadyFlag(resultReadyFlag),
    .serialClock(serialClock), .serialClockOe_n(serialClockOe_n),
    .calBusy(calBusy));
